/* File: dacr_cfg.svh */
`ifndef DACR_CFG_SVH
`define DACR_CFG_SVH

// ******************************************************
// Register offsets
// ******************************************************
`define DACR_OFS_DATA_LOW  8'hfb
`define DACR_OFS_DATA_HIGH 8'hfc
`define DACR_OFS_CONTROL   8'hfd

// ******************************************************
// Control field positions
// ******************************************************
`define DACR_BIT_OUTPUT_PIN  4
`define DACR_BIT_EIGHT_BIT   3
`define DACR_BIT_RANGE       2
`define DACR_BIT_CLEAR_N     1
`define DACR_BIT_ENABLE      0
`define DACR_CTRL_WR_MASK    8'h1f

// ******************************************************
// Reset values
// ******************************************************
`define DACR_RST_DATA_LOW  8'h00
`define DACR_RST_DATA_HIGH 8'h00
`define DACR_RST_CONTROL   8'h00
`define DACR_RST_CODE      12'h000

`endif

/* File: dacr_control.sv */
`timescale 1ns/100ps
`default_nettype none
`include "dacr_cfg.svh"

module dacr_control
(
  input  wire logic       clk,          // Core clock, 200 MHz
  input  wire logic       reset,        // Synchronous, active high
  input  wire logic [7:0] regAddr,      // Register address
  input  wire logic [7:0] regWrData,    // Write data
  input  wire logic       regWr,        // Write strobe
  input  wire logic       regRd,        // Read strobe
  output logic      [7:0] regRdData,    // Read data, cycle after strobe
  output logic     [11:0] dacCode,      // Code to the converter
  output logic            outPinAlt,    // High selects alternate pin
  output logic            rangeSupply,  // High selects supply range
  output logic            powerDown     // High powers converter down
);

  // ******************************************************
  // Helper functions
  // ******************************************************

  // Address decode, used by write and read paths
  function automatic dacr_pkg::dacr_sel_t selOf(input logic [7:0] a);
    dacr_pkg::dacr_sel_t s;
    s = dacr_pkg::DACR_SEL_NONE;
    if (a == `DACR_OFS_DATA_LOW)
      s = dacr_pkg::DACR_SEL_LOW;
    else if (a == `DACR_OFS_DATA_HIGH)
      s = dacr_pkg::DACR_SEL_HIGH;
    else if (a == `DACR_OFS_CONTROL)
      s = dacr_pkg::DACR_SEL_CTRL;
    return s;
  endfunction

  // Code assembly; upper nibble of high byte never used
  function automatic dacr_pkg::dacr_code_t codeOf(
    input logic                eightBit,
    input dacr_pkg::dacr_byte_t lo,
    input dacr_pkg::dacr_byte_t hi
  );
    dacr_pkg::dacr_code_t c;
    if (eightBit)
      c = {lo, 4'h0};
    else
      c = {hi[3:0], lo};
    return c;
  endfunction

  // ******************************************************
  // Register state
  // ******************************************************
  dacr_pkg::dacr_byte_t ctrl_r;
  dacr_pkg::dacr_byte_t ctrl_nxt;
  dacr_pkg::dacr_byte_t low_r;
  dacr_pkg::dacr_byte_t low_nxt;
  dacr_pkg::dacr_byte_t high_r;
  dacr_pkg::dacr_byte_t high_nxt;
  dacr_pkg::dacr_code_t code_r;
  dacr_pkg::dacr_code_t code_nxt;
  dacr_pkg::dacr_byte_t rdData_r;
  dacr_pkg::dacr_byte_t rdData_nxt;
  logic                 pinAlt_r;
  logic                 pinAlt_nxt;
  logic                 range_r;
  logic                 range_nxt;
  logic                 pwrDown_r;
  logic                 pwrDown_nxt;
  dacr_pkg::dacr_sel_t  sel;
  logic                 clearHold;

  assign sel = selOf(regAddr);
  // Clear bit low means data registers stay at zero
  assign clearHold = ~ctrl_nxt[`DACR_BIT_CLEAR_N];

  // ******************************************************
  // Control register
  // ******************************************************

  // Reserved bits masked off so they never hold state
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    if (regWr && sel == dacr_pkg::DACR_SEL_CTRL)
      ctrl_nxt = regWrData & `DACR_CTRL_WR_MASK;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      ctrl_r <= `DACR_RST_CONTROL;
    else
      ctrl_r <= ctrl_nxt;
  end

  // ******************************************************
  // Data registers
  // ******************************************************

  // Writes lost while clear is held; hold takes effect with the write
  always_comb
  begin
    low_nxt  = low_r;
    high_nxt = high_r;
    if (regWr && sel == dacr_pkg::DACR_SEL_LOW)
      low_nxt = regWrData;
    if (regWr && sel == dacr_pkg::DACR_SEL_HIGH)
      high_nxt = regWrData;
    if (clearHold)
    begin
      low_nxt  = `DACR_RST_DATA_LOW;
      high_nxt = `DACR_RST_DATA_HIGH;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      low_r  <= `DACR_RST_DATA_LOW;
      high_r <= `DACR_RST_DATA_HIGH;
    end
    else
    begin
      low_r  <= low_nxt;
      high_r <= high_nxt;
    end
  end

  // ******************************************************
  // Converter code and analog controls
  // ******************************************************

  // Code moves only on a low byte write or to zero on a clear, so a high byte write
  // alone never produces a half-updated glitch at the output
  always_comb
  begin
    code_nxt = code_r;
    if (regWr && sel == dacr_pkg::DACR_SEL_LOW)
      code_nxt = codeOf(ctrl_r[`DACR_BIT_EIGHT_BIT],
                        low_nxt, high_r);
    if (clearHold)
      code_nxt = `DACR_RST_CODE;
    pinAlt_nxt  = ctrl_nxt[`DACR_BIT_OUTPUT_PIN];
    range_nxt   = ctrl_nxt[`DACR_BIT_RANGE];
    pwrDown_nxt = ~ctrl_nxt[`DACR_BIT_ENABLE];
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      code_r    <= `DACR_RST_CODE;
      pinAlt_r  <= 1'b0;
      range_r   <= 1'b0;
      pwrDown_r <= 1'b1;
    end
    else
    begin
      code_r    <= code_nxt;
      pinAlt_r  <= pinAlt_nxt;
      range_r   <= range_nxt;
      pwrDown_r <= pwrDown_nxt;
    end
  end

  // ******************************************************
  // Read port
  // ******************************************************

  // Unmapped addresses read zero; data valid one cycle only
  always_comb
  begin
    rdData_nxt = 8'h00;
    if (regRd)
    begin
      case (sel)
        dacr_pkg::DACR_SEL_LOW:  rdData_nxt = low_r;
        dacr_pkg::DACR_SEL_HIGH: rdData_nxt = high_r;
        dacr_pkg::DACR_SEL_CTRL: rdData_nxt = ctrl_r;
        default:                 rdData_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      rdData_r <= 8'h00;
    else
      rdData_r <= rdData_nxt;
  end

  assign regRdData   = rdData_r;
  assign dacCode     = code_r;
  assign outPinAlt   = pinAlt_r;
  assign rangeSupply = range_r;
  assign powerDown   = pwrDown_r;

  // ******************************************************
  // Assertions
  // ******************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_ctrlWr;
    regWr && regAddr == `DACR_OFS_CONTROL;
  endsequence

  sequence s_lowWr;
    regWr && regAddr == `DACR_OFS_DATA_LOW && ctrl_r[1];
  endsequence

  property p_resvZero;
    regRd && regAddr == `DACR_OFS_CONTROL |=> regRdData[7:5] == 3'h0;
  endproperty
  a_resvZero: assert property (p_resvZero)
    else $error("reserved control bits read nonzero");

  property p_pinSel;
    s_ctrlWr |=> outPinAlt == $past(regWrData[4]);
  endproperty
  a_pinSel: assert property (p_pinSel)
    else $error("pin select does not follow control write");

  property p_eightBit;
    s_lowWr and ctrl_r[3] |=> dacCode == {$past(regWrData), 4'h0};
  endproperty
  a_eightBit: assert property (p_eightBit)
    else $error("eight-bit code wrong");

  property p_fullCode;
    s_lowWr and !ctrl_r[3]
      |=> dacCode == {$past(high_r[3:0]), $past(regWrData)};
  endproperty
  a_fullCode: assert property (p_fullCode)
    else $error("twelve-bit code wrong");

  property p_range;
    s_ctrlWr |=> rangeSupply == $past(regWrData[2]);
  endproperty
  a_range: assert property (p_range)
    else $error("range select does not follow control write");

  property p_clearHold;
    !ctrl_r[1] |-> low_r == 8'h00 && high_r == 8'h00 && dacCode == 12'h000;
  endproperty
  a_clearHold: assert property (p_clearHold)
    else $error("data not held at zero while clear low");

  property p_powerDown;
    s_ctrlWr |=> powerDown == !$past(regWrData[0]);
  endproperty
  a_powerDown: assert property (p_powerDown)
    else $error("power-down does not follow enable bit");

  property p_lowReadBack;
    s_lowWr ##1 (regRd && regAddr == `DACR_OFS_DATA_LOW && ctrl_r[1])
      |=> regRdData == $past(regWrData, 2);
  endproperty
  a_lowReadBack: assert property (p_lowReadBack)
    else $error("low byte read back wrong");

  property p_highOnly;
    regWr && regAddr == `DACR_OFS_DATA_HIGH && ctrl_r[1] |=> $stable(dacCode);
  endproperty
  a_highOnly: assert property (p_highOnly)
    else $error("code moved on high byte write");

  property p_resetVals;
    disable iff (1'b0)
    reset |=> low_r == 8'h00 && high_r == 8'h00 && ctrl_r == 8'h00;
  endproperty
  a_resetVals: assert property (p_resetVals)
    else $error("registers not zero after reset");

  property p_nibbleIgnored;
    s_lowWr and !ctrl_r[3] |=> dacCode[11:8] == high_r[3:0];
  endproperty
  a_nibbleIgnored: assert property (p_nibbleIgnored)
    else $error("upper nibble leaked into code");

  property p_fullMode;
    s_lowWr and !ctrl_r[3] |=> dacCode[3:0] == $past(regWrData[3:0]);
  endproperty
  a_fullMode: assert property (p_fullMode)
    else $error("full mode low bits not from low byte");

endmodule
`default_nettype wire

/* File: dacr_control_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "dacr_cfg.svh"

module dacr_control_tb;

  // ****************************************************
  // Clock, ports and model state
  // ****************************************************
  logic                 clk       = 1'b0;
  logic                 reset     = 1'b1;
  logic [7:0]           regAddr   = 8'h00;
  logic [7:0]           regWrData = 8'h00;
  logic                 regWr     = 1'b0;
  logic                 regRd     = 1'b0;
  logic [7:0]           regRdData;
  logic [11:0]          dacCode;
  logic                 outPinAlt;
  logic                 rangeSupply;
  logic                 powerDown;
  dacr_pkg::dacr_byte_t mCtrl, mLo, mHi, rnd, rA, rD;
  dacr_pkg::dacr_code_t mCode;
  int                   n_mismatch = 0;
  int                   n_compared = 0;
  int                   cycles     = 0;

  // 200 MHz core clock
  always #2.5 clk = ~clk;

  dacr_control dut
  (
    .clk         (clk),
    .reset       (reset),
    .regAddr     (regAddr),
    .regWrData   (regWrData),
    .regWr       (regWr),
    .regRd       (regRd),
    .regRdData   (regRdData),
    .dacCode     (dacCode),
    .outPinAlt   (outPinAlt),
    .rangeSupply (rangeSupply),
    .powerDown   (powerDown)
  );

  // ****************************************************
  // Expectation functions
  // ****************************************************
  function automatic dacr_pkg::dacr_byte_t lfsrNext(dacr_pkg::dacr_byte_t s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Eight-bit mode left-aligns the low byte, else right-justified
  function automatic dacr_pkg::dacr_code_t expCode(logic e,
    dacr_pkg::dacr_byte_t lo, dacr_pkg::dacr_byte_t hi);
    return e ? {lo, 4'h0} : {hi[3:0], lo};
  endfunction

  function automatic dacr_pkg::dacr_byte_t expRd(logic [7:0] a);
    if (a == `DACR_OFS_DATA_LOW) return mLo;
    if (a == `DACR_OFS_DATA_HIGH) return mHi;
    if (a == `DACR_OFS_CONTROL) return mCtrl;
    return 8'h00;
  endfunction

  // ****************************************************
  // Bus and check tasks
  // ****************************************************
  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic chkOuts();
    chk("dacCode", 16'(dacCode), 16'(mCode));
    chk("outPinAlt", 16'(outPinAlt), 16'(mCtrl[4]));
    chk("rangeSupply", 16'(rangeSupply), 16'(mCtrl[2]));
    // Logical not keeps the inverted enable one bit wide
    chk("powerDown", 16'(powerDown), 16'(!mCtrl[0]));
  endtask

  // Model follows the write as the edge takes it
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    regWr     <= 1'b1;
    regRd     <= 1'b0;
    regAddr   <= a;
    regWrData <= d;
    if (a == `DACR_OFS_CONTROL)
    begin
      mCtrl = d & `DACR_CTRL_WR_MASK;
      if (!mCtrl[1])
      begin
        mLo   = 8'h00;
        mHi   = 8'h00;
        mCode = 12'h000;
      end
    end
    else if (mCtrl[1] && a == `DACR_OFS_DATA_HIGH)
      mHi = d;
    else if (mCtrl[1] && a == `DACR_OFS_DATA_LOW)
    begin
      mLo   = d;
      mCode = expCode(mCtrl[3], d, mHi);
    end
  endtask

  task automatic idle();
    @(posedge clk);
    regWr <= 1'b0;
    regRd <= 1'b0;
    #1 chkOuts();
  endtask

  task automatic rd(logic [7:0] a);
    @(posedge clk);
    regWr   <= 1'b0;
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk("regRdData", 16'(regRdData), 16'(expRd(a)));
  endtask

  task automatic doReset(int n);
    reset <= 1'b1;
    repeat (n) @(posedge clk);
    reset <= 1'b0;
    mCtrl = 8'h00;
    mLo   = 8'h00;
    mHi   = 8'h00;
    mCode = 12'h000;
    #1 chkOuts();
  endtask

  task automatic test_done();
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard, well above the expected run length
  always @(posedge clk)
  begin
    cycles++;
    if (cycles >= 20000)
    begin
      n_mismatch++;
      test_done();
    end
  end

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial
  begin
    doReset(6);
    // Reset values and data writes dropped while clear is low
    for (int i = 0; i < 3; i++)
      rd(8'hfb + 8'(i));
    wr(`DACR_OFS_DATA_HIGH, 8'h0a);
    wr(`DACR_OFS_DATA_LOW, 8'h55);
    idle();
    rd(`DACR_OFS_DATA_LOW);
    // Walk: enable, high then low, read back, then read data returns to zero
    wr(`DACR_OFS_CONTROL, 8'h03);
    wr(`DACR_OFS_DATA_HIGH, 8'h0a);
    idle();
    wr(`DACR_OFS_DATA_LOW, 8'h55);
    idle();
    rd(`DACR_OFS_DATA_LOW);
    @(posedge clk);
    #1 chk("regRdData idle", 16'(regRdData), 16'h0000);
    // Upper nibble ignored in the code but read back
    wr(`DACR_OFS_DATA_HIGH, 8'hf3);
    wr(`DACR_OFS_DATA_LOW, 8'h21);
    idle();
    rd(`DACR_OFS_DATA_HIGH);
    // All control bits set, eight-bit mode, reserved bits read zero
    wr(`DACR_OFS_CONTROL, 8'hff);
    idle();
    rd(`DACR_OFS_CONTROL);
    wr(`DACR_OFS_DATA_LOW, 8'hc7);
    idle();
    // Clear bit dropped with data present
    wr(`DACR_OFS_CONTROL, 8'h1d);
    idle();
    rd(`DACR_OFS_DATA_HIGH);
    // Random back-to-back traffic, unmapped addresses among it
    rnd = 8'h49;
    for (int i = 0; i < 300; i++)
    begin
      rnd = lfsrNext(rnd);
      rA  = (rnd[7:6] == 2'b00) ? lfsrNext(rnd) : 8'hfa + 8'(rnd[1:0]);
      rnd = lfsrNext(rnd);
      rD  = rnd;
      if (rA == `DACR_OFS_CONTROL)
        rD[1] = rD[1] | rnd[4];
      wr(rA, rD);
      if (rnd[0])
        idle();
      rd(rA);
      rd(8'hfb + 8'(rnd[2:1]));
    end
    // Reset in mid-run brings data and control registers back to zero, power-down high
    @(posedge clk);
    doReset(2);
    for (int i = 0; i < 3; i++)
      rd(8'hfb + 8'(i));
    test_done();
  end

endmodule

`default_nettype wire

/* File: dacr_pkg.sv */
`default_nettype none

package dacr_pkg;

  // Register byte and converter code types
  typedef logic [7:0]  dacr_byte_t;
  typedef logic [11:0] dacr_code_t;

  // Which register an address selects
  typedef enum logic [1:0] {
    DACR_SEL_NONE = 2'b00,
    DACR_SEL_LOW  = 2'b01,
    DACR_SEL_HIGH = 2'b10,
    DACR_SEL_CTRL = 2'b11
  } dacr_sel_t;

endpackage

`default_nettype wire
